// File: core/mcpfs_pkg.sv
// Package of constants and carrier types for the pin-function select block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package mcpfs_pkg;
   // Port modes
   localparam logic MODE_SPI = 1'h0;
   localparam logic MODE_UART = 1'h1;
   // Ramp status field that feeds the interrupt
   localparam int RAMP_IRQ_LO = 4;
   localparam int RAMP_IRQ_HI = 7;
   localparam int ENC_NULL_BIT = 0;
   // Pump clock: half period in oscillator ticks, full period sixteen
   localparam logic [3:0] PUMP_DIV_MSB_RST = 4'h0;
   localparam int PUMP_DIV_BITS = 4;
   // Counter widths and reset values
   localparam int ENC_W = 32;
   localparam int PRESC_W = 16;
   localparam logic [31:0] ENC_CNT_RST = 32'h0000_0000;
   localparam logic [15:0] PRESC_RST = 16'h0000;
   localparam int N_AXES = 2;
   // Synchronised pin inputs of one axis
   typedef struct packed {
      logic enc_a;
      logic enc_b;
      logic enc_n;
      logic stop_left;
      logic stop_right;
   } mcpfs_axis_pins_t;
   // Two-signal view of a two-way pin
   typedef struct packed {
      logic dout;
      logic oe_n;
   } mcpfs_pin_drv_t;
endpackage

// File: core/mcpfs_top.sv
// Pin-function and clock-source selection logic of a dual stepper controller
`timescale 1ns/1ns
module mcpfs_top (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic host_port_select_strap_i,
   input wire logic diff_mode_i,
   input wire logic ring_mode_i,
   input wire logic poscmp_enable_i,
   input wire logic [7:0] ramp_status_i,
   input wire logic [7:0] encoder_event_flags_i,
   input wire logic axis1_cmp_result_i,
   input wire logic [3:0] gpio_out_i,
   input wire logic [3:0] gpio_oe_n_i,
   input wire logic spi_sdo_data_i,
   input wire logic uart_tx_i,
   input wire logic uart_tx_en_i,
   input wire logic ring_tx_i,
   input wire logic csn_io0_i,
   input wire logic sck_io1_i,
   input wire logic sdi_io2_i,
   input wire logic sdo_io3_i,
   input wire logic single_wire_line_pos_i,
   input wire logic single_wire_line_neg_i,
   input wire logic enc1_a_or_irq_pin_i,
   input wire logic enc1_b_or_cmp_pin_i,
   input wire logic enc1_n_i,
   input wire logic enc2_a_i,
   input wire logic enc2_b_i,
   input wire logic ext_clk_i,
   input wire logic power_stage_disable_n_i,
   input wire logic axis1_left_stop_i,
   input wire logic axis1_right_stop_i,
   input wire logic axis2_left_stop_i,
   input wire logic axis2_right_stop_i,
   input wire logic [15:0] enc1_presc_i,
   input wire logic [15:0] enc2_presc_i,
   output logic uart_mode_o,
   output logic csn_o,
   output logic sck_o,
   output logic sdi_o,
   output logic [3:0] gpio_in_o,
   output logic [3:0] gpio_pin_out_o,
   output logic [3:0] gpio_pin_oe_n_o,
   output logic uart_rx_o,
   output logic multi_in_pos_o,
   output logic multi_in_neg_o,
   output logic swp_out_o,
   output logic swp_oe_n_o,
   output logic swn_out_o,
   output logic swn_oe_n_o,
   output logic enc1a_out_o,
   output logic enc1a_oe_n_o,
   output logic enc1b_out_o,
   output logic enc1b_oe_n_o,
   output logic int_osc_en_o,
   output logic pump_clock_out_o,
   output logic coils_float_o,
   output logic [31:0] enc1_pos_o,
   output logic [31:0] enc2_pos_o,
   output logic [3:0] stops_o
);

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   localparam int NS = 18;
   logic [NS-1:0] async_in;
   logic [NS-1:0] meta_r;
   logic [NS-1:0] sync_r;
   assign async_in = {host_port_select_strap_i, csn_io0_i, sck_io1_i,
      sdi_io2_i, sdo_io3_i, single_wire_line_pos_i, single_wire_line_neg_i,
      enc1_a_or_irq_pin_i, enc1_b_or_cmp_pin_i, enc1_n_i, enc2_a_i,
      enc2_b_i, ext_clk_i, power_stage_disable_n_i, axis1_left_stop_i,
      axis1_right_stop_i, axis2_left_stop_i, axis2_right_stop_i};
   // Two stages, first read only by second
   always_ff @(posedge sys_clk_i) begin
      meta_r <= async_in;
      sync_r <= meta_r;
   end

   wire s_strap = sync_r[17];
   wire [3:0] s_io = sync_r[16:13];
   wire s_swp = sync_r[12];
   wire s_swn = sync_r[11];
   wire s_e1a = sync_r[10];
   wire s_e1b = sync_r[9];
   wire s_e1n = sync_r[8];
   wire s_e2a = sync_r[7];
   wire s_e2b = sync_r[6];
   wire s_clk = sync_r[5];
   wire s_dis = sync_r[4];
   wire [3:0] s_stop = sync_r[3:0];

   // ------------------------------------------------------------------
   // Pin function selection
   // ------------------------------------------------------------------
   wire uart_sel = (s_strap == mcpfs_pkg::MODE_UART);
   // Pin levels in IO order, bit k is IOk like the pin drivers
   wire [3:0] io_pins = {s_io[0], s_io[1], s_io[2], s_io[3]};
   wire sdo_drive = !uart_sel && !s_io[3];
   wire irq_level = (|ramp_status_i[mcpfs_pkg::RAMP_IRQ_HI:
      mcpfs_pkg::RAMP_IRQ_LO]) ||
      encoder_event_flags_i[mcpfs_pkg::ENC_NULL_BIT];
   wire swp_drive = uart_sel && uart_tx_en_i;
   wire swn_diff = uart_sel && diff_mode_i && uart_tx_en_i;
   wire swn_ring = uart_sel && ring_mode_i;
   wire enc2_null = uart_sel ? 1'b0 : s_swn;
   wire e1a_in = poscmp_enable_i ? 1'b0 : s_e1a;
   wire e1b_in = poscmp_enable_i ? 1'b0 : s_e1b;

   mcpfs_pkg::mcpfs_pin_drv_t swn_nxt;
   assign swn_nxt = {swn_ring ? ring_tx_i : !uart_tx_i,
      !(swn_ring || swn_diff)};

   // Serial port pins as pin drivers or GPIO
   logic [3:0] io_out_nxt;
   logic [3:0] io_oe_n_nxt;
   always_comb begin
      if (uart_sel) begin
         io_out_nxt = gpio_out_i;
         io_oe_n_nxt = gpio_oe_n_i;
      end else begin
         io_out_nxt = {spi_sdo_data_i, 3'h0};
         io_oe_n_nxt = {!sdo_drive, 3'h7};
      end
   end

   // Registered pin outputs
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         uart_mode_o <= 1'b0;
         csn_o <= 1'b1;
         sck_o <= 1'b0;
         sdi_o <= 1'b0;
         gpio_in_o <= 4'h0;
         gpio_pin_out_o <= 4'h0;
         gpio_pin_oe_n_o <= 4'hF;
         uart_rx_o <= 1'b1;
         multi_in_pos_o <= 1'b0;
         multi_in_neg_o <= 1'b0;
         swp_out_o <= 1'b0;
         swp_oe_n_o <= 1'b1;
         swn_out_o <= 1'b0;
         swn_oe_n_o <= 1'b1;
         enc1a_out_o <= 1'b0;
         enc1a_oe_n_o <= 1'b1;
         enc1b_out_o <= 1'b0;
         enc1b_oe_n_o <= 1'b1;
         coils_float_o <= 1'b1;
         stops_o <= 4'h0;
      end else begin
         uart_mode_o <= uart_sel;
         csn_o <= uart_sel ? 1'b1 : s_io[3];
         sck_o <= uart_sel ? 1'b0 : s_io[2];
         sdi_o <= uart_sel ? 1'b0 : s_io[1];
         gpio_in_o <= uart_sel ? io_pins : 4'h0;
         gpio_pin_out_o <= io_out_nxt;
         gpio_pin_oe_n_o <= io_oe_n_nxt;
         uart_rx_o <= uart_sel ? s_swp : 1'b1;
         multi_in_pos_o <= uart_sel ? 1'b0 : s_swp;
         multi_in_neg_o <= enc2_null;
         swp_out_o <= uart_tx_i;
         swp_oe_n_o <= !swp_drive;
         swn_out_o <= swn_nxt.dout;
         swn_oe_n_o <= swn_nxt.oe_n;
         enc1a_out_o <= irq_level;
         enc1a_oe_n_o <= !poscmp_enable_i;
         enc1b_out_o <= axis1_cmp_result_i;
         enc1b_oe_n_o <= !poscmp_enable_i;
         coils_float_o <= s_dis;
         stops_o <= s_stop;
      end
   end

   // ------------------------------------------------------------------
   // Clock source and pump clock
   // ------------------------------------------------------------------
   logic osc_off_r;
   logic [3:0] pump_div_r;
   // Sticky: cleared only by reset, which stands in for power down
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         osc_off_r <= 1'b0;
         int_osc_en_o <= 1'b1;
      end else begin
         osc_off_r <= osc_off_r || s_clk;
         int_osc_en_o <= !(osc_off_r || s_clk);
      end
   end
   // Divide by sixteen: output is the divider MSB
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pump_div_r <= mcpfs_pkg::PUMP_DIV_MSB_RST;
         pump_clock_out_o <= 1'b0;
      end else begin
         pump_div_r <= pump_div_r + 4'h1;
         pump_clock_out_o <= pump_div_r[mcpfs_pkg::PUMP_DIV_BITS-1];
      end
   end

   // ------------------------------------------------------------------
   // Encoder counters, one per axis
   // ------------------------------------------------------------------
   mcpfs_pkg::mcpfs_axis_pins_t ax [mcpfs_pkg::N_AXES];
   assign ax[0] = '{e1a_in, e1b_in, s_e1n, s_stop[3], s_stop[2]};
   assign ax[1] = '{s_e2a, s_e2b, enc2_null, s_stop[1], s_stop[0]};
   wire [15:0] presc [mcpfs_pkg::N_AXES];
   assign presc[0] = enc1_presc_i;
   assign presc[1] = enc2_presc_i;
   logic [31:0] pos_r [mcpfs_pkg::N_AXES];
   assign enc1_pos_o = pos_r[0];
   assign enc2_pos_o = pos_r[1];

   genvar g;
   generate
      for (g = 0; g < mcpfs_pkg::N_AXES; g++) begin : g_enc
         logic a_d_r;
         logic b_d_r;
         logic [15:0] acc_r;
         // Quadrature step and direction from previous sample
         wire step = (ax[g].enc_a ^ a_d_r) ^ (ax[g].enc_b ^ b_d_r);
         wire up = ax[g].enc_a ^ b_d_r;
         wire wrap = (acc_r >= presc[g]);
         always_ff @(posedge sys_clk_i) begin
            if (!resetn_i) begin
               a_d_r <= 1'b0;
               b_d_r <= 1'b0;
               acc_r <= mcpfs_pkg::PRESC_RST;
               pos_r[g] <= mcpfs_pkg::ENC_CNT_RST;
            end else begin
               a_d_r <= ax[g].enc_a;
               b_d_r <= ax[g].enc_b;
               if (step) begin
                  // Prescaler: one motor count per presc+1 edges
                  acc_r <= wrap ? mcpfs_pkg::PRESC_RST : acc_r + 16'h1;
                  if (wrap) begin
                     pos_r[g] <= up ? pos_r[g] + 32'h1
                        : pos_r[g] - 32'h1;
                  end
               end
            end
         end
      end
   endgenerate

endmodule // mcpfs_top

// File: test/mcpfs_monitor.sv
// Checker of the pin-function select block, bound to its top ports
`timescale 1ns/1ns
module mcpfs_monitor (
   input logic sys_clk_i,
   input logic resetn_i,
   input logic host_port_select_strap_i,
   input logic poscmp_enable_i,
   input logic [7:0] ramp_status_i,
   input logic [7:0] encoder_event_flags_i,
   input logic axis1_cmp_result_i,
   input logic csn_io0_i,
   input logic ext_clk_i,
   input logic power_stage_disable_n_i,
   input logic uart_mode_o,
   input logic [3:0] gpio_pin_oe_n_o,
   input logic csn_o,
   input logic enc1a_out_o,
   input logic enc1a_oe_n_o,
   input logic enc1b_out_o,
   input logic enc1b_oe_n_o,
   input logic int_osc_en_o,
   input logic pump_clock_out_o,
   input logic coils_float_o
);
   // ----
   // Settling count after reset, flushes the synchronisers
   // ----
   logic [2:0] up_r;
   wire rdy = up_r[2];
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) up_r <= 3'h0;
      else if (!rdy) up_r <= up_r + 3'h1;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Pin-derived outputs follow three edges behind
   AST_HOST_MODE:
      assert property (rdy |-> uart_mode_o ==
         $past(host_port_select_strap_i, 3)) else $error("mode wrong");
   AST_SDO_TRISTATE:
      assert property (rdy && !uart_mode_o |-> gpio_pin_oe_n_o[3] ==
         $past(csn_io0_i, 3)) else $error("data out drive wrong");
   AST_SELECT_IDLE:
      assert property (rdy && uart_mode_o |-> csn_o)
         else $error("select not idle");
   AST_IRQ_PIN:
      assert property (rdy && $past(poscmp_enable_i) |-> !enc1a_oe_n_o &&
         enc1a_out_o == ((|$past(ramp_status_i[7:4])) ||
         $past(encoder_event_flags_i[0]))) else $error("irq pin wrong");
   AST_CMP_PIN:
      assert property (rdy && $past(poscmp_enable_i) |-> !enc1b_oe_n_o &&
         enc1b_out_o == $past(axis1_cmp_result_i)) else $error("cmp wrong");
   AST_ENC_INPUTS:
      assert property (rdy && !$past(poscmp_enable_i) |-> enc1a_oe_n_o &&
         enc1b_oe_n_o) else $error("encoder pins driven");
   AST_OSC_OFF:
      assert property (rdy && $past(ext_clk_i, 3) |-> !int_osc_en_o)
         else $error("oscillator not off");
   AST_OSC_STICKY:
      assert property (!int_osc_en_o |=> !int_osc_en_o)
         else $error("oscillator back on");
   AST_PUMP_HALF:
      assert property ($rose(pump_clock_out_o) |-> pump_clock_out_o [*8]
         ##1 !pump_clock_out_o) else $error("pump half period wrong");
   AST_COILS:
      assert property (rdy |-> coils_float_o ==
         $past(power_stage_disable_n_i, 3)) else $error("coils wrong");
   // Main scenarios
   cover property (rdy && !gpio_pin_oe_n_o[3]);
   cover property ($fell(int_osc_en_o));
   cover property (rdy && uart_mode_o);
endmodule // mcpfs_monitor

bind mcpfs_top mcpfs_monitor u_mon (.*);

// File: test/mcpfs_host.sv
// Host model: drives the port strap and the four serial pins
`timescale 1ns/1ns
module mcpfs_host (
   input logic sys_clk_i,
   input logic uart_sel_i,
   input logic cs_req_i,
   input logic [3:0] pin_out_i,
   input logic [3:0] pin_oe_n_i,
   output logic strap_o,
   output logic [3:0] pin_o
);
   // Released data line shows the inverse of its last value
   logic sdo_last_r = 1'b0;
   // Clock and data in follow the request so the core sees them move
   wire [3:0] host_drv = {~sdo_last_r, cs_req_i, cs_req_i, ~cs_req_i};
   assign strap_o = uart_sel_i;
   // Device drive wins where enabled, host value elsewhere
   assign pin_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & host_drv);
   always_ff @(posedge sys_clk_i) begin
      if (!pin_oe_n_i[3]) sdo_last_r <= pin_out_i[3];
   end
endmodule // mcpfs_host

// File: test/tb_motion_ctrl_pin_function_select.sv
// Testbench of the pin-function select block
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
 $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_motion_ctrl_pin_function_select;
   logic sys_clk_i = 0, resetn_i = 0, diff_mode_i = 0, ring_mode_i = 0;
   logic poscmp_enable_i = 0, axis1_cmp_result_i = 0, spi_sdo_data_i = 1;
   logic uart_tx_i = 0, uart_tx_en_i = 0, ring_tx_i = 0, enc1_n_i = 0;
   logic single_wire_line_pos_i = 0, single_wire_line_neg_i = 0;
   logic enc1_a_or_irq_pin_i = 0, enc1_b_or_cmp_pin_i = 0, ext_clk_i = 0;
   logic enc2_a_i = 0, enc2_b_i = 0, power_stage_disable_n_i = 0;
   logic axis1_left_stop_i = 0, axis1_right_stop_i = 0;
   logic axis2_left_stop_i = 0, axis2_right_stop_i = 0;
   logic [7:0] ramp_status_i = 0, encoder_event_flags_i = 0;
   logic [3:0] gpio_out_i = 0, gpio_oe_n_i = 0;
   logic [15:0] enc1_presc_i = 0, enc2_presc_i = 0;
   logic uart_sel = 0, cs_req = 0;
   wire host_port_select_strap_i, csn_io0_i, sck_io1_i, sdi_io2_i, sdo_io3_i;
   logic uart_mode_o, csn_o, sck_o, sdi_o, uart_rx_o, multi_in_pos_o;
   logic multi_in_neg_o, swp_out_o, swp_oe_n_o, swn_out_o, swn_oe_n_o;
   logic enc1a_out_o, enc1a_oe_n_o, enc1b_out_o, enc1b_oe_n_o, int_osc_en_o;
   logic pump_clock_out_o, coils_float_o;
   logic [3:0] gpio_in_o, gpio_pin_out_o, gpio_pin_oe_n_o, stops_o;
   logic [31:0] enc1_pos_o, enc2_pos_o;
   logic [5:0] tg;
   logic last;
   int n_errors = 0, total_checks = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   mcpfs_top DUT (.*);
   mcpfs_host HOST (.sys_clk_i(sys_clk_i), .uart_sel_i(uart_sel),
      .cs_req_i(cs_req), .pin_out_i(gpio_pin_out_o),
      .pin_oe_n_i(gpio_pin_oe_n_o), .strap_o(host_port_select_strap_i),
      .pin_o({sdo_io3_i, sdi_io2_i, sck_io1_i, csn_io0_i}));
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      n_errors++;
      print_verdict();
   end
   // ----
   // Main sequence
   // ----
   initial begin
      step(10);
      resetn_i = 1;
      step(4);
      `CHK(int_osc_en_o, 1'b1);
      `CHK(uart_mode_o, 1'b0);
      `CHK(gpio_pin_oe_n_o[3], 1'b1);
      `CHK(gpio_in_o, 4'h0);
      cs_req = 1; single_wire_line_pos_i = 1; single_wire_line_neg_i = 1;
      step(5);
      `CHK({gpio_pin_oe_n_o[3], gpio_pin_out_o[3]}, 2'h1);
      `CHK({csn_o, uart_rx_o, multi_in_pos_o}, 3'h3);
      `CHK({sck_o, sdi_o}, 2'h3);
      `CHK(multi_in_neg_o, 1'b1);
      {axis1_left_stop_i, axis1_right_stop_i} = 2'h2;
      {axis2_left_stop_i, axis2_right_stop_i} = 2'h1;
      for (int i = 0; i < 2; i++) begin
         power_stage_disable_n_i = i[0];
         step(5);
         `CHK(coils_float_o, i[0]);
      end
      `CHK(stops_o, 4'h9);
      poscmp_enable_i = 1; axis1_cmp_result_i = 1;
      for (int i = 0; i < 9; i++) begin
         ramp_status_i = 8'h01 << i;
         encoder_event_flags_i = {7'h00, i == 8};
         {enc1_a_or_irq_pin_i, enc1_b_or_cmp_pin_i} = {i[1] ^ i[0], i[1]};
         step(2);
         `CHK({enc1a_oe_n_o, enc1a_out_o}, {1'b0, i >= 4});
      end
      `CHK({enc1b_oe_n_o, enc1b_out_o}, 2'h1);
      poscmp_enable_i = 0; step(2);
      `CHK(enc1b_oe_n_o, 1'b1);
      `CHK(enc1_pos_o, 32'h0000_0000);
      // Pump toggles four times in thirty-two cycles
      tg = 0; last = pump_clock_out_o;
      repeat (32) begin
         step(1);
         tg += 6'(pump_clock_out_o != last);
         last = pump_clock_out_o;
      end
      `CHK(tg, 6'h04);
      // Axis 2 four steps up, axis 1 four steps down at two per count
      enc1_presc_i = 16'h0001;
      for (int i = 1; i < 5; i++) begin
         {enc2_a_i, enc2_b_i} = {i[1] ^ i[0], i[1]};
         {enc1_a_or_irq_pin_i, enc1_b_or_cmp_pin_i} = {i[1], i[1] ^ i[0]};
         step(5);
      end
      `CHK(enc2_pos_o, 32'h0000_0004);
      `CHK(enc1_pos_o, 32'hFFFF_FFFE);
      ext_clk_i = 1; step(5); ext_clk_i = 0; step(5);
      `CHK(int_osc_en_o, 1'b0);
      uart_sel = 1; gpio_out_i = 4'h5; single_wire_line_pos_i = 0;
      uart_tx_en_i = 1; uart_tx_i = 1; diff_mode_i = 1;
      step(8);
      `CHK({uart_mode_o, csn_o}, 2'h3);
      `CHK({gpio_pin_oe_n_o, gpio_pin_out_o, gpio_in_o}, 12'h055);
      `CHK({sck_o, sdi_o}, 2'h0);
      `CHK(multi_in_neg_o, 1'b0);
      `CHK({uart_rx_o, swp_oe_n_o, swp_out_o}, 3'h1);
      `CHK({swn_oe_n_o, swn_out_o}, 2'h0);
      ring_mode_i = 1; ring_tx_i = 1; step(3);
      `CHK({swn_oe_n_o, swn_out_o}, 2'h1);
      print_verdict();
   end
endmodule // tb_motion_ctrl_pin_function_select
